/* File: hdl/adcrf_pkg.sv */
package adcrf_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_POS_SEL = 4'h2;
    localparam logic [3:0] ADDR_NEG_SEL = 4'h3;
    localparam logic [3:0] ADDR_RES_HI = 4'h4;
    localparam logic [3:0] ADDR_RES_LO = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
    localparam logic [3:0] ADDR_PORT_MODE = 4'h8;
    localparam logic [3:0] ADDR_PORT_SKIP = 4'h9;
    // ----------------------------------------
    // Control, config and interrupt register fields
    // ----------------------------------------
    localparam int CTRL_LJST_BIT = 0;
    localparam int CTRL_DONE_BIT = 5;
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_EN_BIT = 7;
    localparam int CFG_DIV_LSB = 3;
    localparam int IRQ_DONE_BIT = 0;
    // ----------------------------------------
    // Reset values, selector codes and conversion sizes
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'hF8;
    localparam logic [7:0] PORT_MODE_RESET = 8'hFF;
    localparam logic [7:0] PORT_SKIP_RESET = 8'h00;
    localparam logic [4:0] NEG_SEL_GND = 5'h1F;
    localparam logic [4:0] NEG_SEL_VREF = 5'h1E;
    localparam logic [4:0] POS_SEL_TEMP = 5'h1E;
    localparam logic [4:0] POS_SEL_VDD = 5'h1F;
    localparam int SAR_CLOCKS_PER_CONV = 11;
    localparam int RES_BITS = 10;
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ADCRF_IDLE = 2'b00,
        ADCRF_CONV = 2'b01,
        ADCRF_DONE = 2'b11
    } adcrf_state_t;
endpackage

/* File: hdl/adcrf_res_if.sv */
interface adcrf_res_if;
    logic done;
    logic [9:0] code;
    logic diff_mode;
    logic ljst;
    logic [15:0] packed_word;
    modport seq (output done, output code, input diff_mode, input ljst, input packed_word);
    modport pack (input code, input diff_mode, input ljst, output packed_word);
endinterface

/* File: hdl/adcrf_packer.sv */
module adcrf_packer
    import adcrf_pkg::*;
(
    adcrf_res_if.pack res
);
    // ----------------------------------------
    // Justification and fill
    // ----------------------------------------
    always_comb begin
        if (res.ljst) begin
            res.packed_word = {res.code, 6'h00};
        end else if (res.diff_mode) begin
            res.packed_word = {{6{res.code[9]}}, res.code};
        end else begin
            res.packed_word = {6'h00, res.code};
        end
    end
endmodule

/* File: hdl/adcrf_sar_seq.sv */
module adcrf_sar_seq
    import adcrf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic start,
    input wire logic [4:0] divider,
    input wire logic comp_in,
    output logic sar_clk_en,
    output logic [9:0] trial,
    output logic busy,
    adcrf_res_if.seq res
);
    adcrf_state_t state_q, state_d;
    logic [4:0] div_q, div_d;
    logic [3:0] bit_q, bit_d;
    logic [9:0] sar_q, sar_d;
    logic tick;

    assign tick = (div_q == divider);
    assign sar_clk_en = tick && (state_q == ADCRF_CONV);
    assign trial = sar_q | (10'h200 >> bit_q);
    assign busy = (state_q == ADCRF_CONV);
    assign res.code = sar_q;
    assign res.done = (state_q == ADCRF_DONE);

    // ----------------------------------------
    // Divider and successive approximation
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        div_d = tick ? 5'h00 : div_q + 5'h01;
        bit_d = bit_q;
        sar_d = sar_q;
        case (state_q)
            ADCRF_IDLE: begin
                div_d = 5'h00;
                if (enable && start) begin
                    state_d = ADCRF_CONV;
                    bit_d = 4'h0;
                    sar_d = 10'h000;
                end
            end
            ADCRF_CONV: begin
                if (!enable) begin
                    state_d = ADCRF_IDLE;
                end else if (tick) begin
                    if (comp_in) begin
                        sar_d = trial;
                    end
                    if (bit_q == 4'(RES_BITS - 1)) begin
                        state_d = ADCRF_DONE;
                    end else begin
                        bit_d = bit_q + 4'h1;
                    end
                end
            end
            default: begin
                state_d = ADCRF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ADCRF_IDLE;
            div_q <= 5'h00;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            bit_q <= bit_d;
            sar_q <= sar_d;
        end
    end
endmodule

/* File: hdl/adcrf_top.sv */
// Function
// - Converter runs only while enable set
// - Positive and negative input selectors drive multiplexer
// - Ground negative input means single-ended mode
// - Result bytes written at conversion completion
// - Justify bit zero right, one left
// - Single-ended result is unsigned ten bits
// - Single-ended unused result bits are zero
// - Differential result is signed two's complement
// - Right-justified differential sign-extends high byte
// - Left-justified differential clears low bits
// - Mode bit zero analog, skip bit excludes
// - Busy falling edge sets done and interrupt; here only at completion, not when shutdown cuts a conversion
// - Conversion clock is system over divider+1
//
// Our own choices: the address-and-strobe port and the register offsets.
module adcrf_top
    import adcrf_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // Register port
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    // Analog core
    input wire logic COMP_IN,
    output logic [9:0] DAC_TRIAL_OUT,
    output logic SAR_CLK_EN_OUT,
    output logic ANALOG_PWR_OUT,
    output logic [4:0] POS_SEL_OUT,
    output logic [4:0] NEG_SEL_OUT,
    output logic DIFF_MODE_OUT,
    // Port pins
    output logic [7:0] PIN_ANALOG_OUT,
    output logic [7:0] PIN_XBAR_SKIP_OUT,
    // Interrupt
    output logic IRQ_OUT
);
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] cfg_q, cfg_d;
    logic [4:0] pos_q, pos_d;
    logic [4:0] neg_q, neg_d;
    logic [15:0] result_q, result_d;
    logic done_flag_q, done_flag_d;
    logic irq_stat_q, irq_stat_d;
    logic irq_mask_q, irq_mask_d;
    logic [7:0] pmode_q, pmode_d;
    logic [7:0] pskip_q, pskip_d;
    logic [7:0] rdata_q, rdata_d;
    logic busy_prev_q, busy_prev_d;
    logic busy;
    logic busy_fall;
    logic start;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_pos;
    logic wr_neg;
    logic wr_mask;
    logic wr_pmode;
    logic wr_pskip;
    logic rd_stat;
    adcrf_res_if res_if ();

    // ----------------------------------------
    // Sequencer and packer
    // ----------------------------------------
    assign start = wr_ctrl && REG_WDATA_IN[CTRL_BUSY_BIT];

    adcrf_sar_seq u_seq (
        .clk(CORE_CLK_IN),
        .rst(RST_IN),
        .enable(ctrl_q[CTRL_EN_BIT]),
        .start(start),
        .divider(cfg_q[7:CFG_DIV_LSB]),
        .comp_in(COMP_IN),
        .sar_clk_en(SAR_CLK_EN_OUT),
        .trial(DAC_TRIAL_OUT),
        .busy(busy),
        .res(res_if)
    );

    adcrf_packer u_pack (
        .res(res_if)
    );

    assign res_if.diff_mode = (neg_q != NEG_SEL_GND);
    assign res_if.ljst = ctrl_q[CTRL_LJST_BIT];
    assign busy_fall = busy_prev_q && !busy && res_if.done;

    // ----------------------------------------
    // Outputs to analog core and pins
    // ----------------------------------------
    assign ANALOG_PWR_OUT = ctrl_q[CTRL_EN_BIT];
    assign POS_SEL_OUT = pos_q;
    assign NEG_SEL_OUT = neg_q;
    assign DIFF_MODE_OUT = res_if.diff_mode;
    assign PIN_ANALOG_OUT = ~pmode_q;
    assign PIN_XBAR_SKIP_OUT = pskip_q;
    assign REG_RDATA_OUT = rdata_q;
    assign IRQ_OUT = irq_stat_q && irq_mask_q;

    // ----------------------------------------
    // Write address decode
    // ----------------------------------------
    always_comb begin
        wr_ctrl = 1'b0;
        wr_cfg = 1'b0;
        wr_pos = 1'b0;
        wr_neg = 1'b0;
        wr_mask = 1'b0;
        wr_pmode = 1'b0;
        wr_pskip = 1'b0;
        if (REG_WR_IN) begin
            if (REG_ADDR_IN == ADDR_CTRL) begin
                wr_ctrl = 1'b1;
            end else if (REG_ADDR_IN == ADDR_CFG) begin
                wr_cfg = 1'b1;
            end else if (REG_ADDR_IN == ADDR_POS_SEL) begin
                wr_pos = 1'b1;
            end else if (REG_ADDR_IN == ADDR_NEG_SEL) begin
                wr_neg = 1'b1;
            end else if (REG_ADDR_IN == ADDR_IRQ_MASK) begin
                wr_mask = 1'b1;
            end else if (REG_ADDR_IN == ADDR_PORT_MODE) begin
                wr_pmode = 1'b1;
            end else if (REG_ADDR_IN == ADDR_PORT_SKIP) begin
                wr_pskip = 1'b1;
            end
        end
    end

    assign rd_stat = REG_RD_IN && (REG_ADDR_IN == ADDR_IRQ_STAT);

    // ----------------------------------------
    // Control register and done flag
    // ----------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        done_flag_d = done_flag_q;
        if (wr_ctrl) begin
            ctrl_d = REG_WDATA_IN & 8'h81;
            done_flag_d = REG_WDATA_IN[CTRL_DONE_BIT];
        end
        if (busy_fall) begin
            done_flag_d = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_q <= CTRL_RESET;
            done_flag_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            done_flag_q <= done_flag_d;
        end
    end

    // ----------------------------------------
    // Divider and input selectors
    // ----------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        pos_d = pos_q;
        neg_d = neg_q;
        if (wr_cfg) begin
            cfg_d = {REG_WDATA_IN[7:CFG_DIV_LSB], 3'h0};
        end
        if (wr_pos) begin
            pos_d = REG_WDATA_IN[4:0];
        end
        if (wr_neg) begin
            neg_d = REG_WDATA_IN[4:0];
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cfg_q <= CFG_RESET;
            pos_q <= 5'h00;
            neg_q <= 5'h00;
        end else begin
            cfg_q <= cfg_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
        end
    end

    // ----------------------------------------
    // Port pin mode and skip
    // ----------------------------------------
    always_comb begin
        pmode_d = pmode_q;
        pskip_d = pskip_q;
        if (wr_pmode) begin
            pmode_d = REG_WDATA_IN;
        end
        if (wr_pskip) begin
            pskip_d = REG_WDATA_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pmode_q <= PORT_MODE_RESET;
            pskip_q <= PORT_SKIP_RESET;
        end else begin
            pmode_q <= pmode_d;
            pskip_q <= pskip_d;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    always_comb begin
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        if (wr_mask) begin
            irq_mask_d = REG_WDATA_IN[IRQ_DONE_BIT];
        end
        if (rd_stat) begin
            irq_stat_d = 1'b0;
        end
        // Completion wins over a clearing read
        if (busy_fall) begin
            irq_stat_d = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_stat_q <= 1'b0;
            irq_mask_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // ----------------------------------------
    // Result capture
    // ----------------------------------------
    always_comb begin
        result_d = result_q;
        busy_prev_d = busy;
        if (busy_fall) begin
            result_d = res_if.packed_word;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            result_q <= 16'h0000;
            busy_prev_q <= 1'b0;
        end else begin
            result_q <= result_d;
            busy_prev_q <= busy_prev_d;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (REG_RD_IN) begin
            if (REG_ADDR_IN == ADDR_CTRL) begin
                rdata_d = ctrl_q;
                rdata_d[CTRL_BUSY_BIT] = busy;
                rdata_d[CTRL_DONE_BIT] = done_flag_q;
            end else if (REG_ADDR_IN == ADDR_CFG) begin
                rdata_d = cfg_q;
            end else if (REG_ADDR_IN == ADDR_POS_SEL) begin
                rdata_d = {3'b000, pos_q};
            end else if (REG_ADDR_IN == ADDR_NEG_SEL) begin
                rdata_d = {3'b000, neg_q};
            end else if (REG_ADDR_IN == ADDR_RES_HI) begin
                rdata_d = result_q[15:8];
            end else if (REG_ADDR_IN == ADDR_RES_LO) begin
                rdata_d = result_q[7:0];
            end else if (REG_ADDR_IN == ADDR_IRQ_STAT) begin
                rdata_d = {7'h00, irq_stat_q};
            end else if (REG_ADDR_IN == ADDR_IRQ_MASK) begin
                rdata_d = {7'h00, irq_mask_q};
            end else if (REG_ADDR_IN == ADDR_PORT_MODE) begin
                rdata_d = pmode_q;
            end else if (REG_ADDR_IN == ADDR_PORT_SKIP) begin
                rdata_d = pskip_q;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
endmodule

/* File: verif/adcrf_core_model.sv */
module adcrf_core_model (
    // Trial code and held input level
    input wire logic [9:0] trial_in,
    input wire logic [9:0] level_in,
    // Comparator decision
    output logic comp_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Keep the trial bit while the input is at or above the trial code
    assign comp_out = level_in >= trial_in;
endmodule

/* File: verif/adcrf_top_asserts.sv */
module adcrf_top_asserts
    import adcrf_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // Register port
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    // Core and pins
    input wire logic SAR_CLK_EN_OUT,
    input wire logic ANALOG_PWR_OUT,
    input wire logic [4:0] POS_SEL_OUT,
    input wire logic [4:0] NEG_SEL_OUT,
    input wire logic DIFF_MODE_OUT,
    input wire logic [7:0] PIN_ANALOG_OUT,
    input wire logic [7:0] PIN_XBAR_SKIP_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    sequence wr_at(logic [3:0] a);
        REG_WR_IN && REG_ADDR_IN == a;
    endsequence
    pin_mode_map_a: assert property (wr_at(ADDR_PORT_MODE) |=>
        PIN_ANALOG_OUT == ~$past(REG_WDATA_IN)) else $error("analog pin map wrong");
    pin_skip_map_a: assert property (wr_at(ADDR_PORT_SKIP) |=>
        PIN_XBAR_SKIP_OUT == $past(REG_WDATA_IN)) else $error("skip map wrong");
    pos_sel_a: assert property (wr_at(ADDR_POS_SEL) |=>
        POS_SEL_OUT == $past(REG_WDATA_IN[4:0])) else $error("positive select wrong");
    neg_sel_a: assert property (wr_at(ADDR_NEG_SEL) |=>
        NEG_SEL_OUT == $past(REG_WDATA_IN[4:0])) else $error("negative select wrong");
    // ----------------------------------------
    // Mode, power and read port
    // ----------------------------------------
    diff_mode_a: assert property (DIFF_MODE_OUT == (NEG_SEL_OUT != NEG_SEL_GND))
        else $error("mode does not follow negative select");
    no_clk_off_a: assert property (!ANALOG_PWR_OUT |-> !SAR_CLK_EN_OUT)
        else $error("conversion clock while shut down");
    stop_on_off_a: assert property (REG_WR_IN && REG_ADDR_IN == ADDR_CTRL &&
        !REG_WDATA_IN[CTRL_EN_BIT] |=> (!ANALOG_PWR_OUT && !SAR_CLK_EN_OUT) [*8])
        else $error("shutdown not held");
    rdata_idle_a: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
        else $error("read data outside read answer");
    unmapped_rd_a: assert property (REG_RD_IN && REG_ADDR_IN > 4'h9 |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind adcrf_top adcrf_top_asserts u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .SAR_CLK_EN_OUT(SAR_CLK_EN_OUT),
    .ANALOG_PWR_OUT(ANALOG_PWR_OUT), .POS_SEL_OUT(POS_SEL_OUT), .NEG_SEL_OUT(NEG_SEL_OUT),
    .DIFF_MODE_OUT(DIFF_MODE_OUT), .PIN_ANALOG_OUT(PIN_ANALOG_OUT),
    .PIN_XBAR_SKIP_OUT(PIN_XBAR_SKIP_OUT));

/* File: verif/testbench.sv */
module testbench;
    import adcrf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [9:0] level = 10'h000;
    logic comp, sar_en, pwr, diff, irq;
    logic [9:0] trial;
    logic [4:0] pos_sel, neg_sel;
    logic [7:0] rdata, pin_an, pin_skip, got;
    int num_errors = 0;
    int checks = 0;
    int gap = 0;
    int last_gap = 0;
    adcrf_top DUT (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .COMP_IN(comp),
        .DAC_TRIAL_OUT(trial), .SAR_CLK_EN_OUT(sar_en), .ANALOG_PWR_OUT(pwr),
        .POS_SEL_OUT(pos_sel), .NEG_SEL_OUT(neg_sel), .DIFF_MODE_OUT(diff),
        .PIN_ANALOG_OUT(pin_an), .PIN_XBAR_SKIP_OUT(pin_skip), .IRQ_OUT(irq));
    adcrf_core_model u_core (.trial_in(trial), .level_in(level), .comp_out(comp));
    initial begin
        forever #25 clk = ~clk;
    end
    // Spacing of conversion clock pulses
    always @(posedge clk) begin
        if (sar_en === 1'b1) begin
            last_gap <= gap;
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end
    task automatic end_of_test();
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // One conversion, then justify flipped before the result is read back
    task automatic convert(input logic lj, input logic [4:0] neg, input logic [9:0] lvl,
                           input logic msk, input logic [15:0] exp);
        logic [7:0] hi, lo;
        int n;
        level <= lvl;
        wr_reg(ADDR_NEG_SEL, {3'h0, neg});
        wr_reg(ADDR_IRQ_MASK, {7'h00, msk});
        wr_reg(ADDR_CTRL, {7'h48, lj});
        rd_reg(ADDR_CTRL, got);
        chk(16'(got), {8'h00, 7'h48, lj});
        n = 0;
        while (got[CTRL_DONE_BIT] !== 1'b1 && n < 100) begin
            rd_reg(ADDR_CTRL, got);
            n++;
        end
        if (n == 100) begin
            num_errors++;
            end_of_test();
        end
        chk(16'(got), {8'h00, 7'h50, lj});
        chk(16'(irq), 16'(msk));
        chk(16'(diff), 16'(neg != NEG_SEL_GND));
        wr_reg(ADDR_CTRL, {7'h40, ~lj});
        rd_reg(ADDR_RES_HI, hi);
        rd_reg(ADDR_RES_LO, lo);
        chk({hi, lo}, exp);
        rd_reg(ADDR_IRQ_STAT, got);
        chk(16'(got), 16'h0001);
        rd_reg(ADDR_IRQ_STAT, got);
        chk(16'(got), 16'h0000);
        chk(16'(irq), 16'h0000);
    endtask
    // Values after reset and an unmapped read
    task automatic reset_values();
        rd_reg(ADDR_CTRL, got);
        chk(16'(got), 16'h0000);
        rd_reg(ADDR_CFG, got);
        chk(16'(got), 16'h00F8);
        rd_reg(ADDR_PORT_MODE, got);
        chk(16'({got, pin_an}), 16'hFF00);
        rd_reg(4'hF, got);
        chk(16'(got), 16'h0000);
    endtask
    // Software puts the chosen pin in analog mode and skips it
    task automatic port_setup();
        wr_reg(ADDR_PORT_MODE, 8'hFE);
        wr_reg(ADDR_PORT_SKIP, 8'h01);
        wr_reg(ADDR_POS_SEL, 8'h01);
        @(negedge clk);
        chk({pin_an, pin_skip}, 16'h0101);
        chk(16'(pos_sel), 16'h0001);
    endtask
    // Start refused while shut down, then a conversion cut by shutdown
    task automatic shutdown_cases();
        wr_reg(ADDR_CTRL, 8'h10);
        repeat (30) @(posedge clk);
        rd_reg(ADDR_CTRL, got);
        chk(16'({got, 7'h00, pwr}), 16'h0000);
        wr_reg(ADDR_CTRL, 8'h80);
        wr_reg(ADDR_CTRL, 8'h90);
        wr_reg(ADDR_CTRL, 8'h00);
        repeat (10) @(posedge clk);
        rd_reg(ADDR_CTRL, got);
        chk(16'({got, 7'h00, pwr}), 16'h0000);
        rd_reg(ADDR_IRQ_STAT, got);
        chk(16'(got), 16'h0000);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        reset_values();
        port_setup();
        shutdown_cases();
        wr_reg(ADDR_CFG, 8'h00);
        wr_reg(ADDR_CTRL, 8'h80);
        convert(1'b0, NEG_SEL_GND, 10'h3FF, 1'b1, 16'h03FF);
        convert(1'b1, NEG_SEL_GND, 10'h3FF, 1'b1, 16'hFFC0);
        convert(1'b0, NEG_SEL_GND, 10'h200, 1'b0, 16'h0200);
        convert(1'b1, NEG_SEL_GND, 10'h200, 1'b1, 16'h8000);
        convert(1'b1, NEG_SEL_GND, 10'h100, 1'b1, 16'h4000);
        convert(1'b0, NEG_SEL_VREF, 10'h200, 1'b1, 16'hFE00);
        convert(1'b1, NEG_SEL_VREF, 10'h200, 1'b1, 16'h8000);
        convert(1'b0, NEG_SEL_VREF, 10'h1FF, 1'b1, 16'h01FF);
        convert(1'b1, NEG_SEL_VREF, 10'h1FF, 1'b1, 16'h7FC0);
        convert(1'b0, NEG_SEL_VREF, 10'h300, 1'b1, 16'hFF00);
        convert(1'b1, NEG_SEL_VREF, 10'h300, 1'b1, 16'hC000);
        chk(16'(last_gap), 16'h0001);
        wr_reg(ADDR_CFG, 8'h18);
        convert(1'b0, 5'h02, 10'h155, 1'b1, 16'h0155);
        chk(16'(last_gap), 16'h0004);
        end_of_test();
    end
endmodule
